/* rtl/mmpt_pkg.sv */
package mmpt_pkg;

  // ----------------------------------------------------------------
  // sizes
  // ----------------------------------------------------------------
  localparam int NUM_MATCH = 7;
  localparam int NUM_OUT = 6;
  localparam int DW = 32;
  localparam int AW = 8;
  localparam int MCTL_W = 3;

  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [AW-1:0] OFF_STATUS = 8'h00;
  localparam logic [AW-1:0] OFF_CTRL = 8'h04;
  localparam logic [AW-1:0] OFF_COUNT = 8'h08;
  localparam logic [AW-1:0] OFF_PRESC = 8'h0C;
  localparam logic [AW-1:0] OFF_PCNT = 8'h10;
  localparam logic [AW-1:0] OFF_MCTL = 8'h14;
  localparam logic [AW-1:0] OFF_MATCH0 = 8'h18;
  localparam logic [AW-1:0] OFF_STEP = 8'h04;
  localparam logic [AW-1:0] OFF_PWMC = 8'h34;
  localparam logic [AW-1:0] OFF_REL = 8'h38;
  localparam logic [AW-1:0] OFF_MASK = 8'h3C;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int CTRL_RUN = 0;
  localparam int CTRL_CRST = 1;
  localparam int CTRL_PWM = 3;
  localparam int MCTL_IRQ = 0;
  localparam int MCTL_RST = 1;
  localparam int MCTL_STOP = 2;
  localparam int PWMC_DBL_LSB = 2;
  localparam int PWMC_OE_LSB = 9;
  localparam int HTRANS_ACT = 1;

  // ----------------------------------------------------------------
  // reset values and ahb answers
  // ----------------------------------------------------------------
  localparam logic [DW-1:0] RST_WORD = 32'h0000_0000;
  localparam logic [DW-1:0] ONE_WORD = 32'h0000_0001;
  localparam logic RESP_OKAY = 1'b0;

  // per-match action controls
  typedef struct packed {
    logic stop;
    logic rst;
    logic irq;
  } mmpt_mctl_s;

  // captured ahb address phase
  typedef struct packed {
    logic wr;
    logic [AW-1:0] off;
  } mmpt_aph_s;

endpackage

/* rtl/mmpt_pwm_timer.sv */
// The implementer's own choices: the register addresses and the AHB-Lite register port.
`timescale 1ns/1ps
// What this block does
// - 32-bit counter advanced through 32-bit prescaler
// - seven match registers drive all edges, actions
// - period match resets count, sets cycle length
// - single-edge output rises at period match
// - single-edge high each cycle unless constant low
// - double-edge output uses rise and fall matches
// - rise first positive pulse, fall first negative
// - double-edge edges anywhere within the cycle
// - six single, up to five double (outputs 2 to 6), or mix
// - match may continue counting, optional interrupt
// - stop-on-match halts counter, optional interrupt
// - reset-on-match clears counter, optional interrupt
// - period and width any whole tick count
// - all outputs share the period match rate
// - in pwm mode new match values applied only after release
// - without pwm mode behaves as plain timer
module mmpt_pwm_timer
  import mmpt_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [DW-1:0] hwdata,
  input wire logic hready,
  output logic [DW-1:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // pulse outputs, bit 0 is output 1
  output logic [NUM_OUT-1:0] pwm_out,
  // level interrupt
  output logic irq
);

  // ----------------------------------------------------------------
  // register bus decode
  // ----------------------------------------------------------------
  function automatic logic is_match_off(input logic [AW-1:0] off,
                                        input int k);
    return off == AW'(OFF_MATCH0 + AW'(k) * OFF_STEP);
  endfunction

  mmpt_aph_s aph;
  logic aph_valid;
  logic [DW-1:0] status;
  logic [DW-1:0] mask;
  logic [DW-1:0] ctrl;
  logic [DW-1:0] count;
  logic [DW-1:0] presc;
  logic [DW-1:0] pcnt;
  logic [DW-1:0] mctl_word;
  logic [DW-1:0] pwmc;
  logic [NUM_MATCH-1:0] pend;
  logic [DW-1:0] mr [NUM_MATCH];
  logic [DW-1:0] mr_act [NUM_MATCH];
  logic [DW-1:0] mr_eff [NUM_MATCH];
  mmpt_mctl_s mctl [NUM_MATCH];
  logic wr_now;
  logic [AW-1:0] wr_off;
  logic [DW-1:0] next_rdata;

  // address phase is taken only when the bus is ready
  assign aph_valid = hsel & htrans[HTRANS_ACT] & hready;
  assign wr_now = aph.wr;
  assign wr_off = aph.off;

  // capture the address phase; data phase follows one cycle later
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      aph <= '0;
    end else begin
      aph.wr <= aph_valid & hwrite;
      aph.off <= haddr[AW-1:0];
    end
  end

  // zero wait states, always okay; unmapped reads give zero
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      hreadyout <= 1'b1;
      hresp <= RESP_OKAY;
    end else begin
      hreadyout <= 1'b1;
      hresp <= RESP_OKAY;
    end
  end

  // read mux, registered so data stands through the data phase
  always_comb begin
    next_rdata = RST_WORD;
    unique case (haddr[AW-1:0])
      OFF_STATUS: next_rdata = status;
      OFF_CTRL: next_rdata = ctrl;
      OFF_COUNT: next_rdata = count;
      OFF_PRESC: next_rdata = presc;
      OFF_PCNT: next_rdata = pcnt;
      OFF_MCTL: next_rdata = mctl_word;
      OFF_PWMC: next_rdata = pwmc;
      OFF_REL: next_rdata = DW'(pend);
      OFF_MASK: next_rdata = mask;
      default: begin
        for (int k = 0; k < NUM_MATCH; k++) begin
          if (is_match_off(haddr[AW-1:0], k)) begin
            next_rdata = mr[k];
          end
        end
      end
    endcase
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      hrdata <= RST_WORD;
    end else if (aph_valid && !hwrite) begin
      hrdata <= next_rdata;
    end
  end

  // ----------------------------------------------------------------
  // prescaler and counter
  // ----------------------------------------------------------------
  logic run;
  logic crst;
  logic pwm_en;
  logic tick;
  logic [NUM_MATCH-1:0] hit;
  logic [NUM_MATCH-1:0] hit_rst;
  logic [NUM_MATCH-1:0] hit_stop;
  logic cyc_start;

  assign run = ctrl[CTRL_RUN];
  assign crst = ctrl[CTRL_CRST];
  assign pwm_en = ctrl[CTRL_PWM];
  assign tick = run & ~crst & (pcnt == presc);

  // pwm mode compares the released copies, timer mode the live ones
  genvar gk;
  generate
    for (gk = 0; gk < NUM_MATCH; gk++) begin : g_match
      assign mctl[gk] = mctl_word[gk*MCTL_W +: MCTL_W];
      assign mr_eff[gk] = pwm_en ? mr_act[gk] : mr[gk];
      assign hit[gk] = tick & (count == mr_eff[gk]);
      // period match always resets while pwm mode is on
      if (gk == 0) begin : g_period
        assign hit_rst[gk] = hit[gk] & (mctl[gk].rst | pwm_en);
      end else begin : g_other
        assign hit_rst[gk] = hit[gk] & mctl[gk].rst;
      end
      assign hit_stop[gk] = hit[gk] & mctl[gk].stop;
    end
  endgenerate

  assign cyc_start = pwm_en & hit_rst[0];

  // prescale counter counts clocks and wraps at the prescale value
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pcnt <= RST_WORD;
    end else if (crst || !run || tick) begin
      pcnt <= RST_WORD;
    end else begin
      pcnt <= pcnt + ONE_WORD;
    end
  end

  // reset beats stop beats advance; a stop holds the value reached
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      count <= RST_WORD;
    end else if (crst || (|hit_rst)) begin
      count <= RST_WORD;
    end else if (wr_now && wr_off == OFF_COUNT) begin
      count <= hwdata;
    end else if (tick && !(|hit_stop)) begin
      count <= count + ONE_WORD;
    end
  end

  // ----------------------------------------------------------------
  // control registers
  // ----------------------------------------------------------------
  // a stop match drops run; a same-cycle software write still lands
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ctrl <= RST_WORD;
    end else if (wr_now && wr_off == OFF_CTRL) begin
      ctrl <= hwdata;
    end else if (|hit_stop) begin
      ctrl[CTRL_RUN] <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      presc <= RST_WORD;
      mctl_word <= RST_WORD;
      pwmc <= RST_WORD;
      mask <= RST_WORD;
    end else if (wr_now) begin
      if (wr_off == OFF_PRESC) presc <= hwdata;
      if (wr_off == OFF_MCTL) mctl_word <= hwdata;
      if (wr_off == OFF_PWMC) pwmc <= hwdata;
      if (wr_off == OFF_MASK) mask <= hwdata;
    end
  end

  // ----------------------------------------------------------------
  // match registers, release and transfer
  // ----------------------------------------------------------------
  // live values take writes at once; active copies move only at the
  // cycle start so a half-updated pair never shapes a pulse
  generate
    for (gk = 0; gk < NUM_MATCH; gk++) begin : g_mr
      always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
          mr[gk] <= RST_WORD;
        end else if (wr_now && is_match_off(wr_off, gk)) begin
          mr[gk] <= hwdata;
        end
      end

      always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
          mr_act[gk] <= RST_WORD;
        end else if (cyc_start && pend[gk]) begin
          mr_act[gk] <= mr[gk];
        end
      end
    end
  endgenerate

  // a release written in the transfer cycle stays pending
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pend <= '0;
    end else begin
      pend <= (pend & ~({NUM_MATCH{cyc_start}} & pend)) |
              ((wr_now && wr_off == OFF_REL) ?
               hwdata[NUM_MATCH-1:0] : '0);
    end
  end

  // ----------------------------------------------------------------
  // interrupts
  // ----------------------------------------------------------------
  logic [NUM_MATCH-1:0] ev;
  logic [NUM_MATCH-1:0] w1c;

  generate
    for (gk = 0; gk < NUM_MATCH; gk++) begin : g_ev
      assign ev[gk] = hit[gk] & mctl[gk].irq;
    end
  endgenerate

  assign w1c = (wr_now && wr_off == OFF_STATUS) ?
               hwdata[NUM_MATCH-1:0] : '0;

  // new events beat a same-cycle clear
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      status <= RST_WORD;
    end else begin
      status[NUM_MATCH-1:0] <= (status[NUM_MATCH-1:0] & ~w1c) | ev;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      irq <= 1'b0;
    end else begin
      irq <= |(status & mask);
    end
  end

  // ----------------------------------------------------------------
  // pulse outputs
  // ----------------------------------------------------------------
  // output n: single edge rises on the period match and falls on
  // match n; double edge rises on match n-1 and falls on match n.
  // a fall in the same tick as a rise wins, so a width equal to the
  // period gives a constant low output
  logic [NUM_OUT-1:0] dbl;
  logic [NUM_OUT-1:0] oe;
  logic [NUM_OUT-1:0] rise;
  logic [NUM_OUT-1:0] fall;
  logic [NUM_OUT-1:0] lvl;

  generate
    for (gk = 0; gk < NUM_OUT; gk++) begin : g_out
      if (gk == 0) begin : g_first
        assign dbl[gk] = 1'b0;
      end else begin : g_sel
        assign dbl[gk] = pwmc[PWMC_DBL_LSB + gk - 1];
      end
      assign oe[gk] = pwmc[PWMC_OE_LSB + gk];
      assign rise[gk] = dbl[gk] ? hit[gk] : cyc_start;
      assign fall[gk] = hit[gk + 1];

      always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
          lvl[gk] <= 1'b0;
        end else if (!pwm_en) begin
          lvl[gk] <= 1'b0;
        end else if (fall[gk]) begin
          lvl[gk] <= 1'b0;
        end else if (rise[gk]) begin
          lvl[gk] <= 1'b1;
        end
      end

      always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
          pwm_out[gk] <= 1'b0;
        end else begin
          pwm_out[gk] <= pwm_en & oe[gk] & next_lvl(lvl[gk], rise[gk],
                                                    fall[gk], pwm_en);
        end
      end
    end
  endgenerate

  function automatic logic next_lvl(input logic cur, input logic r,
                                    input logic f, input logic en);
    return en & ~f & (r | cur);
  endfunction

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  sequence s_plain_tick;
    tick && !(|hit_rst) && !(|hit_stop) && !(wr_now &&
      wr_off == OFF_COUNT);
  endsequence

  sequence s_period_hit;
    pwm_en && hit[0];
  endsequence

  // output 3 in double edge mode, the one the bench configures
  sequence s_dbl_sel;
    pwm_en && dbl[2] && oe[2];
  endsequence

  property p_advance;
    s_plain_tick |=> count == $past(count) + ONE_WORD;
  endproperty
  a_advance: assert property (p_advance)
    else $error("counter did not advance on tick");

  property p_presc_wrap;
    run && !crst && pcnt == presc |=> pcnt == RST_WORD;
  endproperty
  a_presc_wrap: assert property (p_presc_wrap)
    else $error("prescale counter did not wrap");

  property p_period;
    s_period_hit |=> count == RST_WORD;
  endproperty
  a_period: assert property (p_period)
    else $error("period match did not clear count");

  property p_stop;
    |hit_stop && !(wr_now && wr_off == OFF_CTRL) |=> !run;
  endproperty
  a_stop: assert property (p_stop)
    else $error("stop match left counter running");

  // pwm_out takes the new level on the matching edge itself
  property p_single_rise;
    s_period_hit and (!dbl[1] && oe[1] && !hit[2]) |=> pwm_out[1];
  endproperty
  a_single_rise: assert property (p_single_rise)
    else $error("single edge output did not rise");

  property p_dbl_edges;
    s_dbl_sel and hit[3] |=> !pwm_out[2];
  endproperty
  a_dbl_edges: assert property (p_dbl_edges)
    else $error("double edge output did not fall");

  property p_dbl_rise;
    s_dbl_sel and (hit[2] && !hit[3]) |=> pwm_out[2];
  endproperty
  a_dbl_rise: assert property (p_dbl_rise)
    else $error("double edge output did not rise");

  property p_transfer;
    cyc_start && pend[0] |=> mr_act[0] == $past(mr[0]);
  endproperty
  a_transfer: assert property (p_transfer)
    else $error("released value not transferred");

  property p_hold;
    !cyc_start |=> $stable(mr_act[1]);
  endproperty
  a_hold: assert property (p_hold)
    else $error("active match changed outside cycle start");

  property p_irq;
    ev[0] && mask[0] && !(wr_now && wr_off == OFF_MASK) |=> ##1 irq;
  endproperty
  a_irq: assert property (p_irq)
    else $error("unmasked match did not raise interrupt");

  property p_timer_mode;
    !pwm_en [*2] |-> pwm_out == '0;
  endproperty
  a_timer_mode: assert property (p_timer_mode)
    else $error("output active outside pwm mode");

endmodule

/* test/mmpt_load_model.sv */
`timescale 1ns/1ps
// ----------------------------------------------------------------
// power stage stand-in: integrates on time of each gate drive
// ----------------------------------------------------------------
module mmpt_load_model
  import mmpt_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // gate drives from the timer, window restart from the bench
  input wire logic [NUM_OUT-1:0] pwm_out,
  input wire logic clr,
  // on time in clocks and turn-on count per phase
  output logic [NUM_OUT-1:0][15:0] hi_cnt,
  output logic [NUM_OUT-1:0][15:0] rise_cnt
);
  logic [NUM_OUT-1:0] prev;

  // sampled once per clock, like a gate driver with a fixed filter;
  // glitches shorter than a clock would go unseen here
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      hi_cnt <= '0;
      rise_cnt <= '0;
      prev <= '0;
    end else begin
      prev <= pwm_out;
      for (int i = 0; i < NUM_OUT; i++) begin
        if (clr) begin
          hi_cnt[i] <= 16'h0000;
          rise_cnt[i] <= 16'h0000;
        end else begin
          hi_cnt[i] <= hi_cnt[i] + {15'h0000, pwm_out[i]};
          rise_cnt[i] <= rise_cnt[i] + {15'h0000, pwm_out[i] & ~prev[i]};
        end
      end
    end
  end
endmodule

/* test/tb_multi_match_pwm_timer.sv */
`timescale 1ns/1ps
`define CHK(nm, ex, gt) begin \
  tests_run++; \
  if ((ex) !== (gt)) begin \
    err_count++; \
    $display("[ERR] %s exp %0h got %0h", nm, ex, gt); \
  end \
end
module tb_multi_match_pwm_timer
  import mmpt_pkg::*;
;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [DW-1:0] hwdata = 32'h0000_0000;
  logic [DW-1:0] hrdata;
  logic hreadyout, hresp, irq, clr = 1'b0;
  logic [NUM_OUT-1:0] pwm_out;
  logic [NUM_OUT-1:0][15:0] hi, rs;
  logic [31:0] q;
  int err_count = 0;
  int tests_run = 0;
  int seed = 82;
  int cyc = 0;
  int p, ps, w, r, f, n;

  always #5 clk = ~clk;

  mmpt_pwm_timer dut (.clk(clk), .reset_n(reset_n), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .pwm_out(pwm_out), .irq(irq));

  mmpt_load_model load (.clk(clk), .reset_n(reset_n), .pwm_out(pwm_out),
    .clr(clr), .hi_cnt(hi), .rise_cnt(rs));

  // ----------------------------------------------------------------
  // bus master and helpers
  // ----------------------------------------------------------------
  task automatic bus(input logic wr, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] rd);
    @(posedge clk);
    hsel <= 1'b1;
    haddr <= {24'h000000, a};
    htrans <= 2'h2;
    hwrite <= wr;
    do @(posedge clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] dummy;
    bus(1'b1, a, d, dummy);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    bus(1'b0, a, 32'h0000_0000, d);
  endtask

  task automatic wait_clk(input int k);
    repeat (k) @(posedge clk);
  endtask

  // restart the load window, then integrate over exactly k clocks
  task automatic window(input int k);
    @(posedge clk);
    clr <= 1'b1;
    @(posedge clk);
    clr <= 1'b0;
    wait_clk(k);
    #1;
  endtask

  // single edge on time per cycle: high from the period match up to
  // and including the tick that matches the width; width equal to
  // period means off
  function automatic logic [31:0] sgl_hi(int pp, int ww, int pre);
    if (ww >= pp) return 32'h0000_0000;
    return (ww + 1) * (pre + 1);
  endfunction

  // double edge on time per cycle, positive or negative going
  function automatic logic [31:0] dbl_hi(int pp, int rr, int ff, int pre);
    if (rr < ff) return (ff - rr) * (pre + 1);
    return (pp + 1 - (rr - ff)) * (pre + 1);
  endfunction

  task automatic conclude;
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  // hang guard, well above the few thousand clocks the run needs
  always @(posedge clk) begin
    cyc++;
    if (cyc == 60000) begin
      err_count++;
      conclude;
    end
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    wait_clk(16);
    reset_n <= 1'b1;
    rd(OFF_CTRL, q);
    `CHK("ctrl reset", RST_WORD, q)
    rd(8'h40, q);
    `CHK("unmapped", RST_WORD, q)
    `CHK("resp", RESP_OKAY, hresp)
    // stop on match 1 with interrupt, mask closed first
    wr(OFF_MATCH0 + OFF_STEP, 32'h0000_0005);
    wr(OFF_MCTL, 32'h0000_0028);
    wr(OFF_CTRL, 32'h0000_0001);
    wait_clk(20);
    rd(OFF_COUNT, q);
    `CHK("stop count", 32'h0000_0005, q)
    rd(OFF_CTRL, q);
    `CHK("run cleared", 32'h0000_0000, q)
    rd(OFF_STATUS, q);
    `CHK("status", 32'h0000_0002, q)
    `CHK("irq masked", 1'b0, irq)
    wr(OFF_MASK, 32'h0000_0002);
    wait_clk(3);
    `CHK("irq open", 1'b1, irq)
    wr(OFF_STATUS, 32'h0000_0002);
    wait_clk(3);
    `CHK("irq clear", 1'b0, irq)
    // timer mode reset on match 0, outputs enabled but pwm off
    wr(OFF_MATCH0, 32'h0000_0007);
    wr(OFF_MCTL, 32'h0000_0003);
    wr(OFF_PWMC, 32'h0000_7E08);
    wr(OFF_COUNT, 32'h0000_0000);
    wr(OFF_CTRL, 32'h0000_0001);
    for (int i = 0; i < 6; i++) begin
      wait_clk($unsigned($random(seed)) % 9);
      rd(OFF_COUNT, q);
      `CHK("wrap", 1'b1, q <= 32'h0000_0007)
      `CHK("pwm off", 6'h00, pwm_out)
    end
    rd(OFF_STATUS, q);
    `CHK("period event", 1'b1, q[0])
    wr(OFF_MASK, 32'h0000_0001);
    wait_clk(3);
    `CHK("irq period", 1'b1, irq)
    // pwm mode: single on 1 and 2, double on 3, random setups
    wr(OFF_CTRL, 32'h0000_0002);
    wr(OFF_MCTL, 32'h0000_0000);
    for (int it = 0; it < 3; it++) begin
      p = 20 + $unsigned($random(seed)) % 20;
      ps = $unsigned($random(seed)) % 3;
      w = (it == 2) ? p : 1 + $unsigned($random(seed)) % (p - 1);
      r = 1 + $unsigned($random(seed)) % (p - 1);
      f = (r % (p - 1)) + 1;
      if (it == 1) begin
        n = r;
        r = f;
        f = n;
      end
      n = 2 * (p + 1) * (ps + 1);
      wr(OFF_CTRL, 32'h0000_0002);
      wr(OFF_PRESC, ps);
      wr(OFF_MATCH0, p);
      wr(OFF_MATCH0 + OFF_STEP, w);
      wr(OFF_MATCH0 + 2 * OFF_STEP, r);
      wr(OFF_MATCH0 + 3 * OFF_STEP, f);
      wr(OFF_REL, 32'h0000_007F);
      wr(OFF_CTRL, 32'h0000_0009);
      wait_clk(2 * n);
      rd(OFF_REL, q);
      `CHK("pending", 32'h0000_0000, q)
      window(n);
      `CHK("out1 on", 2 * sgl_hi(p, w, ps), {16'h0, hi[0]})
      `CHK("out1 rise", (it == 2) ? 0 : 2, {16'h0, rs[0]})
      `CHK("out2 on", 2 * sgl_hi(p, r, ps), {16'h0, hi[1]})
      `CHK("out3 on", 2 * dbl_hi(p, r, f, ps), {16'h0, hi[2]})
      `CHK("out3 rise", 2, {16'h0, rs[2]})
    end
    // new width held back until released, then taken at cycle start
    w = p / 2;
    wr(OFF_MATCH0 + OFF_STEP, w);
    wait_clk(n);
    window(n);
    `CHK("unreleased", 32'h0000_0000, {16'h0, hi[0]})
    wr(OFF_REL, 32'h0000_0002);
    wait_clk(n);
    rd(OFF_REL, q);
    `CHK("pending clr", 32'h0000_0000, q)
    window(n);
    `CHK("released", 2 * sgl_hi(p, w, ps), {16'h0, hi[0]})
    conclude;
  end
endmodule
